// [hdl/combined_change_latch_defs.vh]
`ifndef COMBINED_CHANGE_LATCH_DEFS_VH
`define COMBINED_CHANGE_LATCH_DEFS_VH

// ---------------------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------------------
`define COMBINED_CHANGE_LATCH_CMD_W            4
`define COMBINED_CHANGE_LATCH_CMD_SET_CMB_EN   4'h1
`define COMBINED_CHANGE_LATCH_CMD_GET_CMB_EN   4'h2
`define COMBINED_CHANGE_LATCH_CMD_SET_FALL_EN  4'h3
`define COMBINED_CHANGE_LATCH_CMD_GET_FALL_EN  4'h4
`define COMBINED_CHANGE_LATCH_CMD_SET_RISE_EN  4'h5
`define COMBINED_CHANGE_LATCH_CMD_GET_RISE_EN  4'h6
`define COMBINED_CHANGE_LATCH_CMD_GET_CMB_LAT  4'h7
`define COMBINED_CHANGE_LATCH_CMD_GET_FALL_LAT 4'h8
`define COMBINED_CHANGE_LATCH_CMD_GET_RISE_LAT 4'h9
`define COMBINED_CHANGE_LATCH_CMD_GET_STATUS   4'hA
`define COMBINED_CHANGE_LATCH_CMD_LOCAL        4'hB
`define COMBINED_CHANGE_LATCH_CMD_LOCKOUT      4'hC
`define COMBINED_CHANGE_LATCH_CMD_REMOTE       4'hD

// ---------------------------------------------------------------------------
// Field positions and values
// ---------------------------------------------------------------------------
`define COMBINED_CHANGE_LATCH_DATA_W           16
`define COMBINED_CHANGE_LATCH_VALUE_MASK       16'h7FFF
`define COMBINED_CHANGE_LATCH_BIT_OUTPUT_FLAG_A      12
`define COMBINED_CHANGE_LATCH_BIT_REMOTE       10
`define COMBINED_CHANGE_LATCH_BIT_HIGH_VOLT    6
`define COMBINED_CHANGE_LATCH_BIT_TOP          15
`define COMBINED_CHANGE_LATCH_RST_MASK         16'h0000
`define COMBINED_CHANGE_LATCH_RST_LATCH        16'h0000

`endif

// [hdl/combined_change_latch_edge_latch.v]
`timescale 1ns/100ps
`include "combined_change_latch_defs.vh"

// ---------------------------------------------------------------------------
// Masked transition latch
// ---------------------------------------------------------------------------
module combined_change_latch_edge_latch
#(
   parameter W = 16
)
(
   input  wire         clk,
   input  wire         rst,
   input  wire [W-1:0] prev,
   input  wire [W-1:0] curr,
   input  wire [W-1:0] enable,
   input  wire         rising,
   input  wire         clr,
   output reg  [W-1:0] latch_r
);

   wire [W-1:0] edge_hit;

   // A set that arrives with a clear survives the clear.
   assign edge_hit = (rising ? (curr & ~prev) : (prev & ~curr)) & enable;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         latch_r <= {W{1'b0}};
      else if (clr)
         latch_r <= edge_hit;
      else
         latch_r <= latch_r | edge_hit;
   end

endmodule

// [hdl/combined_change_latch_regs.v]
`timescale 1ns/100ps
`include "combined_change_latch_defs.vh"

// Operation
// - Combined enable read returns both masks merged into one 16-bit value.
// - Falling mask write loads 16 bits selecting recorded 1-to-0 transitions.
// - Rising mask write loads 16 bits selecting recorded 0-to-1 transitions.
// - Falling mask read returns its contents unchanged.
// - Rising mask read returns its contents unchanged.
// - Combined latch read returns both latches merged, then clears both.
// - Falling latch read returns it and clears only it.
// - Rising latch read returns it and clears only it.
// - Status read returns the live status word, no side effect.
// - Values exchanged are 16 bits limited to 0..32767, top bit unused.
// - Bit 12 output output_flag_a, bit 10 remote, bit 6 high voltage.
// - Local command clears remote state and front-panel lockout.
// - Lock command enters lockout while under remote control.
// - During lockout front-panel operation is ignored until local command.
// - Combined enable write loads the value into both masks.
module combined_change_latch_regs
(
   input  wire        clk,
   input  wire        rst,
   input  wire        cmd_valid,
   input  wire [3:0]  cmd_code,
   input  wire [15:0] cmd_data,
   input  wire [15:0] status_in,
   input  wire        panel_req,
   output reg         rsp_valid_r,
   output reg  [15:0] rsp_data_r,
   output reg         remote_r,
   output reg         lockout_r,
   output reg         panel_ack_r,
   output reg  [15:0] status_word_r
);

   // ------------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------------
   reg  [15:0] stat_s1_r;
   reg  [15:0] stat_s2_r;

   // Each status bit is synchronised on its own, so a change of several bits
   // at once may be seen spread over two cycles.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         stat_s1_r <= 16'h0000;
         stat_s2_r <= 16'h0000;
      end
      else
      begin
         stat_s1_r <= status_in;
         stat_s2_r <= stat_s1_r;
      end
   end

   // ------------------------------------------------------------------------
   // Front-panel request synchroniser
   // ------------------------------------------------------------------------
   reg         panel_s1_r;
   reg         panel_s2_r;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         panel_s1_r <= 1'b0;
         panel_s2_r <= 1'b0;
      end
      else
      begin
         panel_s1_r <= panel_req;
         panel_s2_r <= panel_s1_r;
      end
   end

   // ------------------------------------------------------------------------
   // Live status word with remote flag merged in
   // ------------------------------------------------------------------------
   // Bit 10 carries the remote flag, so remote and local commands show up
   // as status transitions; bits 12 and 6 pass straight through.
   reg  [15:0] live_nxt;

   always @*
   begin
      live_nxt = stat_s2_r & `COMBINED_CHANGE_LATCH_VALUE_MASK;
      live_nxt[`COMBINED_CHANGE_LATCH_BIT_REMOTE] = remote_r;
   end

   // ------------------------------------------------------------------------
   // Previous live word, the reference for transition detection
   // ------------------------------------------------------------------------
   reg  [15:0] live_prev_r;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         live_prev_r <= 16'h0000;
      else
         live_prev_r <= live_nxt;
   end

   // ------------------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------------------
   // True when a strobed command carries the given code.
   function cmd_hit;
      input       valid;
      input [3:0] code;
      input [3:0] want;
      begin
         cmd_hit = valid && (code == want);
      end
   endfunction

   wire is_set_cmb  = cmd_hit(cmd_valid, cmd_code, `COMBINED_CHANGE_LATCH_CMD_SET_CMB_EN);
   wire is_set_fall = cmd_hit(cmd_valid, cmd_code, `COMBINED_CHANGE_LATCH_CMD_SET_FALL_EN);
   wire is_set_rise = cmd_hit(cmd_valid, cmd_code, `COMBINED_CHANGE_LATCH_CMD_SET_RISE_EN);
   wire is_rd_cmb   = cmd_hit(cmd_valid, cmd_code, `COMBINED_CHANGE_LATCH_CMD_GET_CMB_LAT);
   wire is_rd_fall  = cmd_hit(cmd_valid, cmd_code, `COMBINED_CHANGE_LATCH_CMD_GET_FALL_LAT);
   wire is_rd_rise  = cmd_hit(cmd_valid, cmd_code, `COMBINED_CHANGE_LATCH_CMD_GET_RISE_LAT);
   wire is_local    = cmd_hit(cmd_valid, cmd_code, `COMBINED_CHANGE_LATCH_CMD_LOCAL);
   wire is_lockout  = cmd_hit(cmd_valid, cmd_code, `COMBINED_CHANGE_LATCH_CMD_LOCKOUT);
   wire is_remote   = cmd_hit(cmd_valid, cmd_code, `COMBINED_CHANGE_LATCH_CMD_REMOTE);

   // ------------------------------------------------------------------------
   // Write value
   // ------------------------------------------------------------------------
   // Bit 15 is dropped here, so no mask can ever hold it.
   wire [15:0] wr_val = cmd_data & `COMBINED_CHANGE_LATCH_VALUE_MASK;

   // ------------------------------------------------------------------------
   // Falling-change enable mask
   // ------------------------------------------------------------------------
   reg  [15:0] fall_en_r;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         fall_en_r <= `COMBINED_CHANGE_LATCH_RST_MASK;
      else if (is_set_cmb || is_set_fall)
         fall_en_r <= wr_val;
   end

   // ------------------------------------------------------------------------
   // Rising-change enable mask
   // ------------------------------------------------------------------------
   reg  [15:0] rise_en_r;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         rise_en_r <= `COMBINED_CHANGE_LATCH_RST_MASK;
      else if (is_set_cmb || is_set_rise)
         rise_en_r <= wr_val;
   end

   // ------------------------------------------------------------------------
   // Falling-change latch
   // ------------------------------------------------------------------------
   // Both latches compare against the same one-cycle-old live word, so each
   // transition is seen in exactly one cycle.
   wire [15:0] fall_lat;
   wire [15:0] rise_lat;

   combined_change_latch_edge_latch #(.W(16)) u_fall
   (
      .clk     (clk),
      .rst     (rst),
      .prev    (live_prev_r),
      .curr    (live_nxt),
      .enable  (fall_en_r),
      .rising  (1'b0),
      .clr     (is_rd_cmb || is_rd_fall),
      .latch_r (fall_lat)
   );

   // ------------------------------------------------------------------------
   // Rising-change latch
   // ------------------------------------------------------------------------
   combined_change_latch_edge_latch #(.W(16)) u_rise
   (
      .clk     (clk),
      .rst     (rst),
      .prev    (live_prev_r),
      .curr    (live_nxt),
      .enable  (rise_en_r),
      .rising  (1'b1),
      .clr     (is_rd_cmb || is_rd_rise),
      .latch_r (rise_lat)
   );

   // ------------------------------------------------------------------------
   // Remote, local and lockout state
   // ------------------------------------------------------------------------
   // Lockout is entered only from remote, so lockout always implies remote.
   localparam [1:0] ST_LOCAL   = 2'b00;
   localparam [1:0] ST_REMOTE  = 2'b01;
   localparam [1:0] ST_LOCKOUT = 2'b10;

   reg  [1:0]  mode_r;
   reg  [1:0]  mode_nxt;

   always @*
   begin
      mode_nxt = mode_r;
      case (mode_r)
         ST_LOCAL:
         begin
            // A lockout command outside remote is ignored.
            if (is_remote)
               mode_nxt = ST_REMOTE;
         end
         ST_REMOTE:
         begin
            if (is_local)
               mode_nxt = ST_LOCAL;
            else if (is_lockout)
               mode_nxt = ST_LOCKOUT;
         end
         ST_LOCKOUT:
         begin
            // A remote command changes nothing while locked out.
            if (is_local)
               mode_nxt = ST_LOCAL;
         end
         default:
            mode_nxt = ST_LOCAL;
      endcase
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mode_r    <= ST_LOCAL;
         remote_r  <= 1'b0;
         lockout_r <= 1'b0;
      end
      else
      begin
         mode_r    <= mode_nxt;
         remote_r  <= (mode_nxt != ST_LOCAL);
         lockout_r <= (mode_nxt == ST_LOCKOUT);
      end
   end

   // ------------------------------------------------------------------------
   // Front-panel gate
   // ------------------------------------------------------------------------
   // The request is held off from the second cycle of lockout_r on and passes
   // again one cycle after the local command has cleared lockout_r.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         panel_ack_r <= 1'b0;
      else
         panel_ack_r <= panel_s2_r && !lockout_r;
   end

   // ------------------------------------------------------------------------
   // Responses
   // ------------------------------------------------------------------------
   // Writes, state commands and unknown codes answer nothing; the data
   // output then rests at zero.
   reg         rsp_nxt;
   reg  [15:0] data_nxt;

   always @*
   begin
      rsp_nxt  = 1'b0;
      data_nxt = 16'h0000;
      if (cmd_valid)
      begin
         if (cmd_code == `COMBINED_CHANGE_LATCH_CMD_GET_CMB_EN)
         begin
            rsp_nxt  = 1'b1;
            data_nxt = fall_en_r | rise_en_r;
         end
         else if (cmd_code == `COMBINED_CHANGE_LATCH_CMD_GET_FALL_EN)
         begin
            rsp_nxt  = 1'b1;
            data_nxt = fall_en_r;
         end
         else if (cmd_code == `COMBINED_CHANGE_LATCH_CMD_GET_RISE_EN)
         begin
            rsp_nxt  = 1'b1;
            data_nxt = rise_en_r;
         end
         else if (cmd_code == `COMBINED_CHANGE_LATCH_CMD_GET_CMB_LAT)
         begin
            rsp_nxt  = 1'b1;
            data_nxt = fall_lat | rise_lat;
         end
         else if (cmd_code == `COMBINED_CHANGE_LATCH_CMD_GET_FALL_LAT)
         begin
            rsp_nxt  = 1'b1;
            data_nxt = fall_lat;
         end
         else if (cmd_code == `COMBINED_CHANGE_LATCH_CMD_GET_RISE_LAT)
         begin
            rsp_nxt  = 1'b1;
            data_nxt = rise_lat;
         end
         else if (cmd_code == `COMBINED_CHANGE_LATCH_CMD_GET_STATUS)
         begin
            rsp_nxt  = 1'b1;
            data_nxt = live_nxt;
         end
      end
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rsp_valid_r <= 1'b0;
         rsp_data_r  <= 16'h0000;
      end
      else
      begin
         rsp_valid_r <= rsp_nxt;
         rsp_data_r  <= data_nxt & `COMBINED_CHANGE_LATCH_VALUE_MASK;
      end
   end

   // ------------------------------------------------------------------------
   // Status word output
   // ------------------------------------------------------------------------
   // A registered copy keeps the merge logic away from the output pin.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         status_word_r <= 16'h0000;
      else
         status_word_r <= live_nxt;
   end

endmodule

// [tb/combined_change_latch_regs_sva.sv]
`timescale 1ns/100ps
module combined_change_latch_regs_sva
(
   input wire        clk,
   input wire        rst,
   input wire        cmd_valid,
   input wire [3:0]  cmd_code,
   input wire [15:0] cmd_data,
   input wire        rsp_valid_r,
   input wire [15:0] rsp_data_r,
   input wire        remote_r,
   input wire        lockout_r,
   input wire        panel_ack_r,
   input wire [15:0] status_word_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_TOP: assert property (!rsp_data_r[15] && !status_word_r[15])
      else $error("top bit set");
   AST_RSP: assert property (rsp_valid_r |-> $past(cmd_valid))
      else $error("answer without command");
   AST_STAT: assert property (cmd_valid && cmd_code == 4'hA |=>
      rsp_valid_r && rsp_data_r == status_word_r)
      else $error("status read");
   AST_FALL: assert property (cmd_valid && cmd_code == 4'h3 ##1
      cmd_valid && cmd_code == 4'h4 |=>
      rsp_data_r == ($past(cmd_data, 2) & 16'h7FFF))
      else $error("fall mask");
   AST_RISE: assert property (cmd_valid && cmd_code == 4'h5 ##1
      cmd_valid && cmd_code == 4'h6 |=>
      rsp_data_r == ($past(cmd_data, 2) & 16'h7FFF))
      else $error("rise mask");
   AST_CMB: assert property (cmd_valid && cmd_code == 4'h1 ##1
      cmd_valid && cmd_code == 4'h2 |=>
      rsp_data_r == ($past(cmd_data, 2) & 16'h7FFF))
      else $error("combined mask");
   AST_LOCAL: assert property (cmd_valid && cmd_code == 4'hB |=>
      !remote_r && !lockout_r) else $error("local");
   AST_LOCK: assert property (cmd_valid && cmd_code == 4'hC &&
      remote_r |=> lockout_r) else $error("lockout");
   AST_PANEL: assert property (lockout_r && $past(lockout_r) |->
      !panel_ack_r) else $error("panel during lockout");
   cover property (cmd_valid && cmd_code == 4'h7 ##1 rsp_data_r != 0);
   cover property ($rose(lockout_r));
   cover property ($fell(panel_ack_r));
endmodule
bind combined_change_latch_regs combined_change_latch_regs_sva u_sva
(
   .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
   .cmd_data(cmd_data), .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r),
   .remote_r(remote_r), .lockout_r(lockout_r), .panel_ack_r(panel_ack_r),
   .status_word_r(status_word_r)
);

// [tb/combined_change_latch_host.sv]
`timescale 1ns/100ps
module combined_change_latch_host
(
   input  wire        clk,
   input  wire        rsp_valid_r,
   input  wire [15:0] rsp_data_r,
   output reg         cmd_valid = 1'b0,
   output reg  [3:0]  cmd_code = 4'h0,
   output reg  [15:0] cmd_data = 16'h0000
);
   // A leading code of zero sends only the second command.
   task xfer(input [3:0] c0, input [15:0] d0, input [3:0] c1,
             input [15:0] d1, output [15:0] q, output got);
   begin
      @(negedge clk);
      if (c0 != 4'h0)
      begin
         cmd_valid = 1'b1;
         cmd_code  = c0;
         cmd_data  = d0 & 16'h7FFF;
         @(negedge clk);
      end
      cmd_valid = 1'b1;
      cmd_code  = c1;
      cmd_data  = d1 & 16'h7FFF;
      @(negedge clk);
      q         = rsp_data_r;
      got       = rsp_valid_r;
      cmd_valid = 1'b0;
      cmd_data  = ~cmd_data;
   end
   endtask
endmodule

// [tb/instrument_status_change_regs_test.sv]
`timescale 1ns/100ps
`define CHK(n, e, a) begin samples_checked = samples_checked + 1; \
   if ((a) !== (e)) begin failures = failures + 1; \
   $display("BAD %0s exp %h got %h", n, e, a); end end
module instrument_status_change_regs_test;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg  [15:0] status_in = 16'h0000;
   reg         panel_req = 1'b0;
   wire        cmd_valid, rsp_valid_r, remote_r, lockout_r, panel_ack_r;
   wire [3:0]  cmd_code;
   wire [15:0] cmd_data, rsp_data_r, status_word_r;
   integer     failures = 0;
   integer     samples_checked = 0;
   reg  [15:0] q;
   reg         got;
   always #4 clk = ~clk;
   combined_change_latch_regs dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_data(cmd_data), .status_in(status_in),
      .panel_req(panel_req), .rsp_valid_r(rsp_valid_r),
      .rsp_data_r(rsp_data_r), .remote_r(remote_r), .lockout_r(lockout_r),
      .panel_ack_r(panel_ack_r), .status_word_r(status_word_r));
   combined_change_latch_host host (.clk(clk), .rsp_valid_r(rsp_valid_r),
      .rsp_data_r(rsp_data_r), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_data(cmd_data));
   task rd(input [3:0] c, input [15:0] e, input [8*12:1] n);
   begin
      host.xfer(4'h0, 16'h0000, c, 16'h0000, q, got);
      `CHK(n, 1'b1, got)
      `CHK(n, e, q)
   end
   endtask
   task wr(input [3:0] c);
   begin
      host.xfer(4'h0, 16'h0000, c, 16'h0000, q, got);
      `CHK("no answer", 1'b0, got)
   end
   endtask
   task setst(input [15:0] v);
   begin
      status_in = v;
      repeat (6) @(negedge clk);
   end
   endtask
   task t_masks;
   begin
      host.xfer(4'h3, 16'h9840, 4'h4, 16'h0000, q, got);
      `CHK("fall mask", 16'h1840, q)
      host.xfer(4'h5, 16'h0041, 4'h6, 16'h0000, q, got);
      `CHK("rise mask", 16'h0041, q)
      rd(4'h2, 16'h1841, "cmb mask");
      rd(4'h4, 16'h1840, "fall again");
      host.xfer(4'h1, 16'h1040, 4'h2, 16'h0000, q, got);
      `CHK("cmb set", 16'h1040, q)
      rd(4'h6, 16'h1040, "rise of cmb");
      $display("t_masks done");
   end
   endtask
   task t_latch;
   begin
      setst(16'h9001);
      setst(16'h8040);
      rd(4'h8, 16'h1000, "fall latch");
      rd(4'h9, 16'h1040, "rise latch");
      rd(4'h7, 16'h0000, "cmb cleared");
      rd(4'hA, 16'h0040, "status");
      `CHK("status word", 16'h0040, status_word_r)
      setst(16'h1040);
      setst(16'h0000);
      rd(4'h7, 16'h1040, "cmb latch");
      rd(4'h8, 16'h0000, "fall clear");
      rd(4'h9, 16'h0000, "rise clear");
      $display("t_latch done");
   end
   endtask
   task t_lock;
   begin
      panel_req = 1'b1;
      setst(16'h0040);
      wr(4'hC);
      `CHK("no lock", 1'b0, lockout_r)
      `CHK("panel ok", 1'b1, panel_ack_r)
      wr(4'hE);
      wr(4'hD);
      wr(4'hC);
      `CHK("lock", 1'b1, lockout_r)
      @(negedge clk);
      `CHK("panel off", 1'b0, panel_ack_r)
      rd(4'hA, 16'h0440, "remote bit");
      wr(4'hB);
      `CHK("local", 1'b0, remote_r | lockout_r)
      repeat (3) @(negedge clk);
      `CHK("panel back", 1'b1, panel_ack_r)
      $display("t_lock done");
   end
   endtask
   task test_done;
   begin
      $display("checked %0d failed %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask
   initial
   begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      t_masks;
      t_latch;
      t_lock;
      test_done;
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      failures = failures + 1;
      $display("timeout");
      test_done;
   end
endmodule
